//--- psw_pkg.sv
// Purpose: Constants for the power-save and wake-up controller.
// Assumes: APB slave with 32-bit data, registers one aligned word each.
// Notes:   Offsets, reset values and cycle counts live here.
package psw_pkg;
  localparam logic [7:0]  OFF_WAKE_EN   = 8'h00;
  localparam logic [7:0]  OFF_WAKE_EDGE = 8'h04;
  localparam logic [7:0]  OFF_WAKE_PEND = 8'h08;
  localparam logic [7:0]  OFF_CTRL      = 8'h0C;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;
  localparam int          CTRL_STOP     = 0;
  localparam int          CTRL_SLEEP    = 1;
  localparam int          CTRL_DELAY    = 2;
  localparam int          CTRL_TICK_IE  = 3;
  localparam int          CTRL_PORTL_IE = 4;
  localparam int          CTRL_GIE      = 5;
  localparam int          CTRL_CLKMON   = 6;
  localparam int          CTRL_RC       = 7;
  localparam int          STAT_TICK_PND = 8;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam int          OSC_DIV       = 10;
  localparam int          STARTUP_COUNT = 256;
  localparam int          TICK_BIT      = 13;
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_STOP  = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WARM  = 4'b1000
  } pm_state_e;
endpackage

//--- power_save_wakeup_ctrl.sv
// Purpose: Deep stop / light sleep sequencer with eight-pin port L wake-up unit.
// Assumes: pclk stands in for the oscillator; port L and oscillator output pin are async.
// Notes:   clocks_run gates the rest of the chip; port L capture works with it low.
// Operation
// - Writing stop request enters deep stop, all clocks and timers halted.
// - In deep stop supervisor inhibited; enabled clock monitor drives supervisor pin low.
// - Deep stop exits on port L wake, oscillator pin rising edge, or reset.
// - Wake enables oscillator and tick timer; 256 instruction clocks then release clocks.
// - Instruction clock is oscillator divided by ten.
// - With RC clock, startup delay only when delay enable set; cleared at reset.
// - Writing sleep request enters light sleep.
// - In sleep oscillator, supervisor, monitor and tick timer run; all else holds.
// - Sleep ends on reset, port L wake, or tick bit thirteen toggle.
// - Each tick bit thirteen toggle sets tick pending; irq only when enabled.
// - Sleep ending with tick irq enabled services it first, else resumes.
// - Wake enable has one bit per port L pin enabling its wake-up.
// - Set edge bit selects falling edge; clear selects rising edge.
// - Pending bit sets on selected edge and holds until software clears it.
// - Stop request ignored while any pin is both enabled and pending.
// - Enable, edge and pending registers read/write, cleared at reset.
// - Port L irqs share one vector, gated by enable bit, port L and global enables.
// - Port L wake with irq enabled services irq first, else resumes.
`timescale 1ns/1ps
`default_nettype none
module power_save_wakeup_ctrl
  import psw_pkg::*;
#(
  parameter int PINS = 8                          // Port L width.
)(
  input  wire logic              pclk,            // APB clock, oscillator stand-in.
  input  wire logic              presetn,         // Async reset, active low.
  input  wire logic              psel,            // APB select.
  input  wire logic              penable,         // APB enable.
  input  wire logic              pwrite,          // APB direction.
  input  wire logic [7:0]        paddr,           // APB byte address.
  input  wire logic [31:0]       pwdata,          // APB write data.
  output logic      [31:0]       prdata,          // APB read data.
  output logic                   pready,          // APB ready.
  output logic                   pslverr,         // APB error on unmapped address.
  input  wire logic [PINS-1:0]   port_l,          // Port L pins, asynchronous.
  input  wire logic              oscillator_output_pin, // Oscillator output pin, async.
  output logic                   clocks_run,      // Clocks routed to the rest of the chip.
  output logic                   osc_enable,      // Oscillator circuitry enabled.
  output logic                   supervisor_output_pin, // Supervisor output, low on fault.
  output logic                   instruction_cycle_clock, // Oscillator divided by ten.
  output logic                   irq_port_l,      // Shared port L interrupt request.
  output logic                   irq_tick,        // Tick timer interrupt request.
  output logic                   service_first    // Wake will service an interrupt first.
);
  import psw_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [PINS-1:0] wake_enable_mask;
  logic [PINS-1:0] wake_edge_select;
  logic [PINS-1:0] wake_pending_flags;
  logic [7:0]      ctrl;
  logic            tick_pending;
  pm_state_e       state;
  pm_state_e       next_state;
  logic [3:0]      div_cnt;
  logic [15:0]     tick_timer;
  logic [8:0]      start_cnt;
  logic [PINS-1:0] pl_s1;
  logic [PINS-1:0] pl_s2;
  logic [PINS-1:0] pl_prev;
  logic [1:0]      osc_s;
  logic            osc_prev;
  logic [1:0]      sync_fill;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  wire             wr_en      = psel & penable & pwrite;
  wire             rd_en      = psel & penable & ~pwrite;
  wire             hit_en     = paddr == OFF_WAKE_EN;
  wire             hit_edge   = paddr == OFF_WAKE_EDGE;
  wire             hit_pend   = paddr == OFF_WAKE_PEND;
  wire             hit_ctrl   = paddr == OFF_CTRL;
  wire             hit_stat   = paddr == OFF_STATUS;
  wire             hit_any    = hit_en | hit_edge | hit_pend | hit_ctrl | hit_stat;
  wire             wr_pend    = wr_en & hit_pend;
  wire             wr_ctrl    = wr_en & hit_ctrl;
  wire             wr_stat    = wr_en & hit_stat;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection and wake conditions.
  // Edges are ignored until the synchroniser holds real pin levels, so a pin high through reset is no edge.
  wire             sync_ok    = sync_fill == 2'h3;
  wire [PINS-1:0]  rise       = {PINS{sync_ok}} & pl_s2 & ~pl_prev;
  wire [PINS-1:0]  fall       = {PINS{sync_ok}} & ~pl_s2 & pl_prev;
  wire [PINS-1:0]  edge_hit   = (wake_edge_select & fall) | (~wake_edge_select & rise);
  wire             armed_pend = |(wake_enable_mask & wake_pending_flags);
  wire             osc_rise   = sync_ok & osc_s[1] & ~osc_prev;
  wire             tc_tick    = div_cnt == 4'(OSC_DIV - 1);
  wire [15:0]      tick_next  = tick_timer + 16'h0001;
  wire             tick_tgl   = tc_tick & (tick_next[TICK_BIT] != tick_timer[TICK_BIT]);
  wire             timers_on  = state != ST_STOP;
  wire             need_delay = ~ctrl[CTRL_RC] | ctrl[CTRL_DELAY];
  wire             stop_req   = wr_ctrl & pwdata[CTRL_STOP] & ~armed_pend;
  wire             sleep_req  = wr_ctrl & pwdata[CTRL_SLEEP];
  wire             wake_stop  = armed_pend | osc_rise;
  wire             wake_sleep = armed_pend | tick_tgl;
  wire             start_done = start_cnt == 9'(STARTUP_COUNT - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Power state selection.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (stop_req)
          next_state = ST_STOP;
        else if (sleep_req)
          next_state = ST_SLEEP;
      end
      ST_STOP:
      begin
        if (wake_stop)
          next_state = need_delay ? ST_WARM : ST_RUN;
      end
      ST_SLEEP:
      begin
        if (wake_sleep)
          next_state = ST_RUN;
      end
      ST_WARM:
      begin
        if (tc_tick && start_done)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port L and oscillator pin synchronisers; they run in every state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pl_s1    <= '0;
      pl_s2    <= '0;
      pl_prev  <= '0;
      osc_s    <= 2'b00;
      osc_prev <= 1'b0;
      sync_fill <= 2'h0;
    end
    else
    begin
      if (!sync_ok)
        sync_fill <= sync_fill + 2'h1;
      pl_s1    <= port_l;
      pl_s2    <= pl_s1;
      pl_prev  <= pl_s2;
      osc_s    <= {osc_s[0], oscillator_output_pin};
      osc_prev <= osc_s[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wake registers; a new edge wins over a software clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_enable_mask   <= RESET_BYTE;
      wake_edge_select   <= RESET_BYTE;
      wake_pending_flags <= RESET_BYTE;
    end
    else
    begin
      if (wr_en && hit_en)
        wake_enable_mask <= pwdata[PINS-1:0];
      if (wr_en && hit_edge)
        wake_edge_select <= pwdata[PINS-1:0];
      wake_pending_flags <= (wr_pend ? pwdata[PINS-1:0] : wake_pending_flags) | edge_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control bits; request bits self-clear, the rest hold.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= RESET_BYTE;
    else if (wr_ctrl)
      ctrl <= {pwdata[7:2], 2'b00};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tick pending flag; a toggle wins over a write of one to clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_pending <= 1'b0;
    else
      tick_pending <= tick_tgl | (tick_pending & ~(wr_stat & pwdata[STAT_TICK_PND]));
  end

  //////////////////////////////////////////////////////////////////////////////
  // State, divider, tick timer and startup counter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= ST_RUN;
      div_cnt    <= 4'h0;
      tick_timer <= 16'h0000;
      start_cnt  <= 9'h000;
    end
    else
    begin
      state <= next_state;
      if (!timers_on)
        div_cnt <= 4'h0;
      else if (tc_tick)
        div_cnt <= 4'h0;
      else
        div_cnt <= div_cnt + 4'h1;
      if (timers_on && tc_tick)
        tick_timer <= tick_next;
      if (state != ST_WARM)
        start_cnt <= 9'h000;
      else if (tc_tick)
        start_cnt <= start_cnt + 9'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata                  <= 32'h0000_0000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      clocks_run              <= 1'b1;
      osc_enable              <= 1'b1;
      supervisor_output_pin   <= 1'b1;
      instruction_cycle_clock <= 1'b0;
      irq_port_l              <= 1'b0;
      irq_tick                <= 1'b0;
      service_first           <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      if (rd_en)
      begin
        prdata <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
        prdata <= hit_en   ? {24'h000000, wake_enable_mask}   :
                  hit_edge ? {24'h000000, wake_edge_select}   :
                  hit_pend ? {24'h000000, wake_pending_flags} :
                  hit_ctrl ? {24'h000000, ctrl}               :
                  hit_stat ? {20'h00000, state, 7'h00, tick_pending} : 32'h0000_0000;
      end
      clocks_run              <= next_state == ST_RUN;
      osc_enable              <= next_state != ST_STOP;
      supervisor_output_pin   <= ~(next_state == ST_STOP && ctrl[CTRL_CLKMON]);
      instruction_cycle_clock <= timers_on & (div_cnt < 4'(OSC_DIV / 2));
      irq_port_l <= ctrl[CTRL_GIE] & ctrl[CTRL_PORTL_IE] & armed_pend;
      irq_tick   <= ctrl[CTRL_GIE] & ctrl[CTRL_TICK_IE] & tick_pending;
      if (state != ST_RUN && next_state == ST_RUN)
        service_first <= (ctrl[CTRL_PORTL_IE] & armed_pend)
                       | (ctrl[CTRL_TICK_IE] & tick_tgl);
      else if (state == ST_RUN && next_state != ST_RUN)
        service_first <= 1'b0;
    end
  end
endmodule // power_save_wakeup_ctrl
`default_nettype wire

//--- psw_checker.sv
// Purpose: Port assertions for the power-save controller.
// Assumes: One pclk domain, presetn async active low.
// Notes:   Bound to the controller below the module.
`timescale 1ns/1ps
`default_nettype none
module psw_checker (
  input wire logic        pclk,                   // Clock.
  input wire logic        presetn,                // Reset, active low.
  input wire logic        psel,                   // Select.
  input wire logic        penable,                // Enable.
  input wire logic        pwrite,                 // Direction.
  input wire logic [31:0] prdata,                 // Read data.
  input wire logic        pready,                 // Ready.
  input wire logic        pslverr,                // Error.
  input wire logic        clocks_run,             // Clocks released.
  input wire logic        osc_enable,             // Oscillator on.
  input wire logic        supervisor_output_pin,  // Supervisor pin.
  input wire logic        instruction_cycle_clock // Divided clock.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The divided clock stays high for five pclk cycles.
  sequence s_tc_high;
    instruction_cycle_clock [*5] ##1 !instruction_cycle_clock;
  endsequence
  // Low-power states, divided clock and bus answers.
  chk_stop_halt: assert property (!osc_enable && !$past(osc_enable) |-> !clocks_run && !instruction_cycle_clock)
    else $error("clocks run in stop");
  chk_tc_period: assert property (disable iff (!presetn || !osc_enable)
    $rose(instruction_cycle_clock) |-> s_tc_high) else $error("divided clock period wrong");
  chk_sup_stop: assert property (!supervisor_output_pin |-> !osc_enable || !$past(osc_enable))
    else $error("supervisor low outside stop");
  chk_sleep_tc: assert property (disable iff (!presetn || !osc_enable)
    !clocks_run |-> ##[1:10] $changed(instruction_cycle_clock)) else $error("divided clock stalled");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_ans: assert property (psel && !penable |=> pready)
    else $error("ready late");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:12] == 20'h0)
    else $error("upper read bits set");
endmodule // psw_checker
bind power_save_wakeup_ctrl psw_checker psw_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clocks_run(clocks_run), .osc_enable(osc_enable), .supervisor_output_pin(supervisor_output_pin),
  .instruction_cycle_clock(instruction_cycle_clock));
`default_nettype wire

//--- psw_pins_model.sv
// Purpose: Signal sources on port L and the oscillator output pin.
// Assumes: Levels change just after a pclk edge.
// Notes:   The bench sets all nine levels at once.
`timescale 1ns/1ps
`default_nettype none
module psw_pins_model (
  input  wire logic       pclk,    // Timing reference.
  output var  logic [7:0] port_l,  // Port L pin levels.
  output var  logic       osc_pin  // Oscillator output pin level.
);
  // All pins start low, so no edge is seen out of reset.
  initial
  begin
    port_l  = 8'h00;
    osc_pin = 1'h0;
  end
  // Moves the pins to new levels.
  task automatic drive(input logic [8:0] v);
    @(posedge pclk);
    {osc_pin, port_l} <= v;
  endtask
endmodule // psw_pins_model
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the power-save controller.
// Assumes: 25 MHz pclk, presetn held for 16 cycles.
// Notes:   Register rows first, then edge, stop, sleep and reset cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psw_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_s;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
  logic [7:0]  paddr = 8'h00, port_l;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, osc_pin, clocks_run, osc_enable, sup, irq_port_l, service_first, irq_tick;
  int          n, n_fail = 0, total_checks = 0;
  row_s        rows [4] = '{'{OFF_WAKE_EN, 32'hA5, 32'hA5, 1'h0}, '{OFF_WAKE_EDGE, 32'h5A, 32'h5A, 1'h0},
                            '{OFF_WAKE_PEND, 32'h3C, 32'h3C, 1'h0}, '{8'h14, 32'hFF, 32'h0, 1'h1}};
  // Columns: control word, wake pins, cycle bounds, expected {clocks_run, osc_enable, sup} levels, service flag.
  int          wtab [4][6] = '{'{32'h41, 32'h002, 2560, 2600, 0, 0}, '{32'h81, 32'h100, 0, 20, 1, 0},
                               '{32'h85, 32'h100, 2560, 2600, 1, 0}, '{32'h32, 32'h002, 0, 2600, 3, 1}};
  power_save_wakeup_ctrl power_save_wakeup_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_l(port_l), .oscillator_output_pin(osc_pin), .clocks_run(clocks_run),
    .osc_enable(osc_enable), .supervisor_output_pin(sup), .instruction_cycle_clock(), .irq_port_l(irq_port_l),
    .irq_tick(irq_tick), .service_first(service_first));
  psw_pins_model psw_pins_model_i (.pclk(pclk), .port_l(port_l), .osc_pin(osc_pin));
  always #20 pclk = ~pclk;
  // Compares and counts.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i])
    begin
      apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      chk({rd, er}, {rows[i].e, rows[i].er});
    end
    apb(1'h1, OFF_WAKE_EDGE, 32'h01);
    apb(1'h1, OFF_WAKE_PEND, 32'h00);
    apb(1'h1, OFF_WAKE_EN, 32'h03);
    psw_pins_model_i.drive(9'h003);
    repeat (4) @(posedge pclk);
    apb(1'h0, OFF_WAKE_PEND, 32'h0);
    chk(rd, 32'h02);
    psw_pins_model_i.drive(9'h002);
    repeat (4) @(posedge pclk);
    apb(1'h0, OFF_WAKE_PEND, 32'h0);
    chk(rd, 32'h03);
    apb(1'h1, OFF_CTRL, 32'h31);
    repeat (4) @(posedge pclk);
    chk({osc_enable, irq_port_l}, 2'h3);
    apb(1'h1, OFF_WAKE_EN, 32'h02);
    foreach (wtab[i])
    begin
      psw_pins_model_i.drive(9'h000);
      apb(1'h1, OFF_WAKE_PEND, 32'h0);
      apb(1'h1, OFF_CTRL, wtab[i][0]);
      repeat (4) @(posedge pclk);
      chk({clocks_run, osc_enable, sup}, wtab[i][4]);
      psw_pins_model_i.drive(wtab[i][1][8:0]);
      n = 0;
      while (clocks_run !== 1'h1 && n < 5000)
      begin
        @(posedge pclk);
        n++;
      end
      chk(n >= wtab[i][2] && n <= wtab[i][3], 1'h1);
      chk(service_first, wtab[i][5]);
    end
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int k = 0; k < 3; k++)
    begin
      apb(1'h0, 8'(4 * k), 32'h0);
      chk(rd, 32'h0);
    end
    chk({irq_tick, irq_port_l, clocks_run}, 3'h1);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
